//--- src/ticu_filter.sv
/*
 * Three-sample digital filter with edge detection for one capture pin.
 * Assumes the pin is synchronous to clk and that sample_en pulses at the
 * chosen sampling rate.
 */
`timescale 1ns/1ps
`default_nettype none
module ticu_filter
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin,
    input wire logic filter_on,
    input wire logic sample_en,
    input wire logic [1:0] edge_cfg,
    output logic edge_hit
);
    logic [2:0] hist;
    logic level;
    logic level_q;
    logic [2:0] next_hist;
    logic next_level;
    logic next_level_q;

    // ------------------------------------------------------------------
    // Filter and edge detection
    // ------------------------------------------------------------------
    // With filter_on set, the accepted level only moves after three equal samples, so a
    // glitch no longer than two sample periods never reaches the capture logic.
    always_comb
    begin
        next_hist = hist;
        next_level = level;
        if (!filter_on)
        begin
            next_level = pin;
        end
        else if (sample_en)
        begin
            next_hist = {hist[1:0], pin};
            if (next_hist == 3'h7)
            begin
                next_level = 1'b1; // R17
            end
            else if (next_hist == 3'h0)
            begin
                next_level = 1'b0; // R17
            end
        end
        next_level_q = level;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hist <= 3'h0;
            level <= 1'b0;
            level_q <= 1'b0;
        end
        else
        begin
            hist <= next_hist;
            level <= next_level;
            level_q <= next_level_q;
        end
    end

    // Edge qualification against the selected polarity.
    always_comb
    begin
        unique case (edge_cfg)
            ticu_pkg::EDGE_RISE: edge_hit = level & ~level_q; // R9
            ticu_pkg::EDGE_FALL: edge_hit = ~level & level_q; // R9
            default: edge_hit = level ^ level_q; // R9
        endcase
    end
endmodule // ticu_filter
`default_nettype wire

//--- src/ticu_pkg.sv
/*
 * Constants for the timer input-capture unit: count-source codes,
 * edge-select codes, filter sampling codes and widths.
 * Assumes nothing of its surroundings; used only by qualified names.
 */
package ticu_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int COUNT_W = 16;
    localparam int NUM_CH = 4;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam int FILTER_MATCHES = 3;

    // ------------------------------------------------------------------
    // Count source select codes (three bits)
    // ------------------------------------------------------------------
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV2 = 3'h1;
    localparam logic [2:0] SRC_DIV4 = 3'h2;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [2:0] SRC_DIV32 = 3'h4;
    localparam logic [2:0] SRC_EXT = 3'h5;
    localparam logic [2:0] SRC_FAST = 3'h6;
    localparam int PRESCALE_W = 5;

    // ------------------------------------------------------------------
    // Edge select codes (two bits per channel)
    // ------------------------------------------------------------------
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // ------------------------------------------------------------------
    // Filter sampling clock select codes
    // ------------------------------------------------------------------
    localparam logic [1:0] FILT_DIV1 = 2'h0;
    localparam logic [1:0] FILT_DIV8 = 2'h1;
    localparam logic [1:0] FILT_DIV32 = 2'h2;
    localparam logic [1:0] FILT_SRC = 2'h3;

    // Channel indices.
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int CH_C = 2;
    localparam int CH_D = 3;
endpackage

//--- src/ticu_top.sv
/*
 * Input-capture mode of a 16-bit free-running timer with four channels.
 * Configuration arrives on plain ports; captured values, the count and
 * event pulses leave on registered outputs. Pins are synchronous to clk.
 */
// Notes on behaviour
// R1: Counter adds one per count-source event and wraps over 65,536 counts.
// R2: Count source: five prescaled clocks, fast oscillator, or external pin rising edges.
// R3: Counting begins when the count-start bit is written 1.
// R4: Writing 0 to the count-start bit halts counting, value is kept.
// R5: A valid channel edge copies the counter into that general register.
// R6: Each capture raises an interrupt request.
// R7: Counter overflow from maximum raises an interrupt request.
// R8: Each pin is independently a port or a capture input.
// R9: Valid edge is rising, falling, or both, per channel.
// R10: Software reads of the counter return the current count.
// R11: Software may write the counter to load a new count.
// R12: Buffer select makes C or D a buffer for A or B.
// R13: Buffered capture moves the old A or B value into its buffer first.
// R14: Software sets C edge select equal to A when C buffers A.
// R15: Software sets D edge select equal to B when D buffers B.
// R16: A buffering C or D still sets its match flag on its pin edge.
// R17: With filter on, a level is accepted after three equal samples.
// R18: The external interrupt pin has no cutoff role in capture mode.
// R19: Counter and general registers are sixteen bits wide.
`timescale 1ns/1ps
`default_nettype none
module ticu_top
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic count_start_bit,
    input wire logic [2:0] count_source_sel,
    input wire logic fast_oscillator_clock,
    input wire logic external_count_clock_pin,
    input wire logic count_write,
    input wire logic [15:0] count_write_data,
    input wire logic [3:0] capture_enable,
    input wire logic [1:0] edge_cfg_a,
    input wire logic [1:0] edge_cfg_b,
    input wire logic [1:0] edge_cfg_c,
    input wire logic [1:0] edge_cfg_d,
    input wire logic buffer_select_c,
    input wire logic buffer_select_d,
    input wire logic filter_enable,
    input wire logic [1:0] filter_clock_sel,
    input wire logic channel_pin_a,
    input wire logic channel_pin_b,
    input wire logic channel_pin_c,
    input wire logic channel_pin_d,
    input wire logic external_interrupt_pin,
    output logic [15:0] timer_count_value,
    output logic [15:0] general_reg_a,
    output logic [15:0] general_reg_b,
    output logic [15:0] general_reg_c,
    output logic [15:0] general_reg_d,
    output logic [3:0] capture_irq,
    output logic overflow_irq,
    output logic match_flag_c,
    output logic match_flag_d,
    output logic ext_irq
);
    logic [15:0] count;
    logic [ticu_pkg::PRESCALE_W-1:0] prescale;
    logic [2:0] ext_hist;
    logic fast_q;
    logic [15:0] gr [ticu_pkg::NUM_CH];
    logic [3:0] cap_irq;
    logic ovf;
    logic mf_c;
    logic mf_d;
    logic ext_q;
    logic ext_irq_r;
    logic [15:0] next_count;
    logic [ticu_pkg::PRESCALE_W-1:0] next_prescale;
    logic [2:0] next_ext_hist;
    logic next_fast_q;
    logic [15:0] next_gr [ticu_pkg::NUM_CH];
    logic [3:0] next_cap_irq;
    logic next_ovf;
    logic next_mf_c;
    logic next_mf_d;
    logic next_ext_q;
    logic next_ext_irq;
    logic tick;
    logic sample_en;
    logic [3:0] pins;
    logic [3:0] hit;
    logic [3:0] pin_event;
    logic [1:0] edge_sel [ticu_pkg::NUM_CH];

    // Returns high when the prescaler is at the end of a divide-by period.
    function automatic logic prescale_done(input logic [4:0] p, input logic [4:0] mask);
        prescale_done = ((p & mask) == mask);
    endfunction

    // ------------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------------
    // The fast oscillator is sampled as a level like any pin; its rising
    // edges count, so it cannot count faster than half of clk.
    always_comb
    begin
        unique case (count_source_sel) // R2
            ticu_pkg::SRC_DIV1: tick = 1'b1;
            ticu_pkg::SRC_DIV2: tick = prescale_done(prescale, 5'h01);
            ticu_pkg::SRC_DIV4: tick = prescale_done(prescale, 5'h03);
            ticu_pkg::SRC_DIV8: tick = prescale_done(prescale, 5'h07);
            ticu_pkg::SRC_DIV32: tick = prescale_done(prescale, 5'h1F);
            ticu_pkg::SRC_EXT: tick = ext_hist[1] & ~ext_hist[2];
            ticu_pkg::SRC_FAST: tick = fast_oscillator_clock & ~fast_q;
            default: tick = 1'b0;
        endcase
        unique case (filter_clock_sel)
            ticu_pkg::FILT_DIV1: sample_en = 1'b1;
            ticu_pkg::FILT_DIV8: sample_en = prescale_done(prescale, 5'h07);
            ticu_pkg::FILT_DIV32: sample_en = prescale_done(prescale, 5'h1F);
            default: sample_en = tick;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // A software write takes priority over a tick in the same cycle.
    always_comb
    begin
        next_prescale = prescale + 5'h01;
        next_ext_hist = {ext_hist[1:0], external_count_clock_pin};
        next_fast_q = fast_oscillator_clock;
        next_count = count;
        next_ovf = 1'b0;
        if (count_write)
        begin
            next_count = count_write_data; // R11
        end
        else if (count_start_bit && tick) // R3 R4
        begin
            next_count = count + 16'h0001; // R1 R19
            next_ovf = (count == ticu_pkg::COUNT_MAX); // R7
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= ticu_pkg::COUNT_RESET;
            prescale <= 5'h00;
            ext_hist <= 3'h0;
            fast_q <= 1'b0;
            ovf <= 1'b0;
        end
        else
        begin
            count <= next_count;
            prescale <= next_prescale;
            ext_hist <= next_ext_hist;
            fast_q <= next_fast_q;
            ovf <= next_ovf;
        end
    end

    // ------------------------------------------------------------------
    // Capture inputs
    // ------------------------------------------------------------------
    assign pins = {channel_pin_d, channel_pin_c, channel_pin_b, channel_pin_a};
    assign edge_sel[ticu_pkg::CH_A] = edge_cfg_a;
    assign edge_sel[ticu_pkg::CH_B] = edge_cfg_b;
    assign edge_sel[ticu_pkg::CH_C] = edge_cfg_c;
    assign edge_sel[ticu_pkg::CH_D] = edge_cfg_d;

    for (genvar i = 0; i < ticu_pkg::NUM_CH; i++)
    begin : g_ch
        ticu_filter u_filter
        (
            .clk(clk),
            .resetn(resetn),
            .pin(pins[i]),
            .filter_on(filter_enable),
            .sample_en(sample_en),
            .edge_cfg(edge_sel[i]),
            .edge_hit(hit[i])
        );
    end

    // ------------------------------------------------------------------
    // General registers and events
    // ------------------------------------------------------------------
    // In buffered mode the C and D edge settings must match A and B, since
    // the buffer shift follows the A and B edge only.
    always_comb
    begin
        for (int k = 0; k < ticu_pkg::NUM_CH; k++)
        begin
            next_gr[k] = gr[k];
        end
        pin_event = hit & capture_enable; // R6 R8
        // A buffering C or D pin is no capture, so only its match flag pulses.
        next_cap_irq = pin_event;
        next_cap_irq[ticu_pkg::CH_C] = pin_event[ticu_pkg::CH_C] & ~buffer_select_c; // R12
        next_cap_irq[ticu_pkg::CH_D] = pin_event[ticu_pkg::CH_D] & ~buffer_select_d; // R12
        if (next_cap_irq[ticu_pkg::CH_A])
        begin
            next_gr[ticu_pkg::CH_A] = count; // R5
            if (buffer_select_c)
            begin
                next_gr[ticu_pkg::CH_C] = gr[ticu_pkg::CH_A]; // R12 R13 R14
            end
        end
        if (next_cap_irq[ticu_pkg::CH_B])
        begin
            next_gr[ticu_pkg::CH_B] = count; // R5
            if (buffer_select_d)
            begin
                next_gr[ticu_pkg::CH_D] = gr[ticu_pkg::CH_B]; // R12 R13 R15
            end
        end
        if (next_cap_irq[ticu_pkg::CH_C] && !buffer_select_c)
        begin
            next_gr[ticu_pkg::CH_C] = count; // R5 R12
        end
        if (next_cap_irq[ticu_pkg::CH_D] && !buffer_select_d)
        begin
            next_gr[ticu_pkg::CH_D] = count; // R5 R12
        end
        next_mf_c = pin_event[ticu_pkg::CH_C]; // R16
        next_mf_d = pin_event[ticu_pkg::CH_D]; // R16
        // The interrupt pin is only an ordinary falling-edge request here.
        next_ext_q = external_interrupt_pin;
        next_ext_irq = ext_q & ~external_interrupt_pin; // R18
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int k = 0; k < ticu_pkg::NUM_CH; k++)
            begin
                gr[k] <= 16'h0000;
            end
            cap_irq <= 4'h0;
            mf_c <= 1'b0;
            mf_d <= 1'b0;
            ext_q <= 1'b1;
            ext_irq_r <= 1'b0;
        end
        else
        begin
            for (int k = 0; k < ticu_pkg::NUM_CH; k++)
            begin
                gr[k] <= next_gr[k];
            end
            cap_irq <= next_cap_irq;
            mf_c <= next_mf_c;
            mf_d <= next_mf_d;
            ext_q <= next_ext_q;
            ext_irq_r <= next_ext_irq;
        end
    end

    // All outputs are flip-flop values.
    assign timer_count_value = count; // R10
    assign general_reg_a = gr[ticu_pkg::CH_A];
    assign general_reg_b = gr[ticu_pkg::CH_B];
    assign general_reg_c = gr[ticu_pkg::CH_C];
    assign general_reg_d = gr[ticu_pkg::CH_D];
    assign capture_irq = cap_irq;
    assign overflow_irq = ovf;
    assign match_flag_c = mf_c;
    assign match_flag_d = mf_d;
    assign ext_irq = ext_irq_r;
endmodule // ticu_top
`default_nettype wire

//--- test/tb.sv
/*
 * Self-checking bench for the timer input-capture unit.
 * Assumes the pin model drives the capture pins and the checker is bound.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0, wr = 1'b0, fast = 1'b0, ext = 1'b0, filt = 1'b0;
    logic bufc = 1'b0, int_n = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [3:0] en = 4'hF;
    logic [1:0] ecfg = 2'h0;
    wire logic [3:0] pins, cirq;
    wire logic [15:0] cnt;
    wire logic [15:0] gr [4];
    logic [1:0] fsel = 2'h0;
    wire logic ovf, mfc, mfd, xirq;
    int err_total = 0, checks = 0;
    integer nmfc = 0, nmfd = 0, novf = 0, nxirq = 0;
    integer ncap [4] = '{default: 0};
    int shf [5] = '{0, 1, 2, 3, 5};

    always #12.5 clk = ~clk;

    // Event pulses last one cycle, so they are tallied at every edge.
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++) ncap[i] += cirq[i];
        nmfc += mfc;
        nmfd += mfd;
        novf += ovf;
        nxirq += xirq;
    end

    ticu_top u_ticu_top (.clk(clk), .resetn(resetn), .count_start_bit(start),
        .count_source_sel(sel), .fast_oscillator_clock(fast),
        .external_count_clock_pin(ext), .count_write(wr), .count_write_data(wdata),
        .capture_enable(en), .edge_cfg_a(ecfg), .edge_cfg_b(ecfg),
        .edge_cfg_c(ecfg), .edge_cfg_d(ecfg),
        .buffer_select_c(bufc), .buffer_select_d(bufc), .filter_enable(filt),
        .filter_clock_sel(fsel), .channel_pin_a(pins[0]),
        .channel_pin_b(pins[1]), .channel_pin_c(pins[2]), .channel_pin_d(pins[3]),
        .external_interrupt_pin(int_n), .timer_count_value(cnt),
        .general_reg_a(gr[0]), .general_reg_b(gr[1]), .general_reg_c(gr[2]),
        .general_reg_d(gr[3]), .capture_irq(cirq), .overflow_irq(ovf),
        .match_flag_c(mfc), .match_flag_d(mfd), .ext_irq(xirq));
    ticu_pin_model u_ticu_pin_model (.clk(clk), .pins(pins));

    // ----------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------
    task automatic slot(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // The write beats the tick, so the count reads v one slot later.
    task automatic load(input logic [15:0] v);
        wr = 1'b1;
        wdata = v;
        start = 1'b1;
        slot(1);
        wr = 1'b0;
        ncap = '{default: 0};
        nmfc = 0;
        nmfd = 0;
        novf = 0;
        nxirq = 0;
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        int exp;
        slot(12);
        resetn = 1'b1;
        slot(1);
        // Each source runs for exactly 64 enabled edges, then stops.
        for (int s = 0; s < 8; s++)
        begin
            sel = s[2:0];
            exp = (s < 5) ? (64 >> shf[s]) : ((s == 7) ? 0 : 7);
            load(16'h0000);
            for (int i = 1; i <= 65; i++)
            begin
                start = (i < 65);
                fast = (s == 6) && (i % 8) >= 4 && i < 58;
                ext = (s == 5) && (i % 8) >= 4 && i < 58;
                slot(1);
            end
            `CHK(cnt, exp[15:0])
            slot(4);
            `CHK(cnt, exp[15:0])
        end
        $display("test sources done");
        sel = ticu_pkg::SRC_DIV1;
        load(16'hFFFE);
        slot(2);
        `CHK(cnt, 16'h0000)
        slot(2);
        `CHK(novf, 1)
        $display("test wrap done");
        for (int ch = 0; ch < 4; ch++)
            for (int m = 0; m < 4; m++)
            begin
                ecfg = m[1:0];
                load(16'h1000);
                u_ticu_pin_model.play(ch, 16'h001E);
                slot(3);
                `CHK(ncap[ch], (m >= 2) ? 2 : 1)
                `CHK(gr[ch], (m == 0) ? 16'h1003 : 16'h1007)
            end
        $display("test edges done");
        ecfg = ticu_pkg::EDGE_RISE;
        en = 4'hD;
        load(16'h1000);
        u_ticu_pin_model.play(1, 16'h001E);
        slot(3);
        `CHK(ncap[1], 0)
        `CHK(gr[1], 16'h1007)
        en = 4'hF;
        $display("test disabled done");
        bufc = 1'b1;
        load(16'h2000);
        fork
            u_ticu_pin_model.play(0, 16'h0066);
            u_ticu_pin_model.play(2, 16'h0600);
            u_ticu_pin_model.play(1, 16'h0066);
            u_ticu_pin_model.play(3, 16'h0600);
        join
        slot(3);
        `CHK(gr[0], 16'h2007)
        `CHK(gr[2], 16'h2003)
        `CHK(gr[1], 16'h2007)
        `CHK(gr[3], 16'h2003)
        `CHK(ncap[2], 0)
        `CHK(ncap[3], 0)
        `CHK(nmfc, 1)
        `CHK(nmfd, 1)
        bufc = 1'b0;
        $display("test buffer done");
        // A two-sample glitch must be swallowed when filtering.
        filt = 1'b1;
        load(16'h3000);
        u_ticu_pin_model.play(0, 16'h07C6);
        slot(3);
        `CHK(ncap[0], 1)
        // At one sample in eight, sixteen high cycles give only two samples.
        fsel = ticu_pkg::FILT_DIV8;
        load(16'h3000);
        u_ticu_pin_model.play(0, 16'hFFFF);
        u_ticu_pin_model.play(0, 16'h0000);
        `CHK(ncap[0], 0)
        repeat (3) u_ticu_pin_model.play(0, 16'hFFFF);
        u_ticu_pin_model.play(0, 16'h0000);
        `CHK(ncap[0], 1)
        fsel = ticu_pkg::FILT_DIV1;
        filt = 1'b0;
        $display("test filter done");
        load(16'h0000);
        int_n = 1'b0;
        slot(2);
        int_n = 1'b1;
        slot(3);
        `CHK(nxirq, 1)
        `CHK(ncap[0] + ncap[1] + ncap[2] + ncap[3], 0)
        $display("test interrupt pin done");
        results();
    end
endmodule // tb
`default_nettype wire

//--- test/ticu_assertions.sv
/*
 * Port checker for the timer input-capture unit.
 * Assumes it is bound to ticu_top; counting checks use the div1 source.
 */
`timescale 1ns/1ps
`default_nettype none
module ticu_assertions
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic count_start_bit,
    input wire logic [2:0] count_source_sel,
    input wire logic count_write,
    input wire logic [15:0] count_write_data,
    input wire logic [3:0] capture_enable,
    input wire logic buffer_select_c,
    input wire logic [15:0] timer_count_value,
    input wire logic [15:0] general_reg_a,
    input wire logic [15:0] general_reg_c,
    input wire logic [3:0] capture_irq,
    input wire logic overflow_irq
);
    // ----------------------------------------------------------
    // Counter checks
    // ----------------------------------------------------------
    // A write always beats a tick, so ticks are only judged without one.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_fast_tick;
        count_start_bit && count_source_sel == ticu_pkg::SRC_DIV1 && !count_write;
    endsequence

    chk_count_step: assert property (s_fast_tick |=>
        timer_count_value == $past(timer_count_value) + 16'h0001) else $error("no count step");
    chk_count_hold: assert property (!count_start_bit && !count_write |=>
        $stable(timer_count_value)) else $error("stopped count moved");
    chk_count_load: assert property (count_write |=>
        timer_count_value == $past(count_write_data)) else $error("count load lost");
    chk_overflow_pulse: assert property (s_fast_tick ##0 timer_count_value == 16'hFFFF
        |-> ##[1:2] overflow_irq) else $error("overflow not flagged");

    // ----------------------------------------------------------
    // Capture checks
    // ----------------------------------------------------------
    // The captured value is the count seen just before the capture edge.
    chk_capture_value: assert property (capture_irq[0] |->
        general_reg_a == $past(timer_count_value)) else $error("bad capture value");
    chk_buffer_shift: assert property (capture_irq[0] && $past(buffer_select_c) |->
        general_reg_c == $past(general_reg_a)) else $error("buffer not shifted");
    chk_buffer_no_cap: assert property ($past(buffer_select_c) |->
        !capture_irq[2]) else $error("buffer captured own pin");
    chk_disabled_quiet: assert property ((!capture_enable[1])[*3] |=>
        !capture_irq[1]) else $error("disabled channel captured");
endmodule // ticu_assertions

bind ticu_top ticu_assertions u_ticu_assertions
(
    .clk(clk), .resetn(resetn), .count_start_bit(count_start_bit),
    .count_source_sel(count_source_sel), .count_write(count_write),
    .count_write_data(count_write_data), .capture_enable(capture_enable),
    .buffer_select_c(buffer_select_c), .timer_count_value(timer_count_value),
    .general_reg_a(general_reg_a), .general_reg_c(general_reg_c),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq)
);
`default_nettype wire

//--- test/ticu_pin_model.sv
/*
 * Pulse source that drives the four capture pins from bit patterns.
 * Assumes the pins are sampled on the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ticu_pin_model
(
    input wire logic clk,
    output logic [3:0] pins
);
    // ----------------------------------------------------------
    // Pattern player
    // ----------------------------------------------------------
    // Levels move 1 ns after an edge, so the design never races them.
    initial pins = 4'h0;

    task automatic play(input int ch, input logic [15:0] pat);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk);
            #1 pins[ch] = pat[i];
        end
    endtask
endmodule // ticu_pin_model
`default_nettype wire
